/* File: design/srf_consts.svh */
`ifndef SRF_CONSTS_SVH
`define SRF_CONSTS_SVH

// System register nibble addresses (row 7, columns 4..F).
`define SRF_OFF_PA_HIGH      7'h74
`define SRF_OFF_PA_UPPER_MID 7'h75
`define SRF_OFF_PA_LOWER_MID 7'h76
`define SRF_OFF_PA_LOW       7'h77
`define SRF_OFF_WINDOW       7'h78
`define SRF_OFF_BANK         7'h79
`define SRF_OFF_IDX_HIGH     7'h7A
`define SRF_OFF_IDX_MID      7'h7B
`define SRF_OFF_IDX_LOW      7'h7C
`define SRF_OFF_GRP_HIGH     7'h7D
`define SRF_OFF_GRP_LOW      7'h7E
`define SRF_OFF_PSW          7'h7F
`define SRF_OFF_FIRST        7'h74

// Reset values.
`define SRF_RST_NIBBLE       4'h0
`define SRF_RST_POINTER      16'h0000
`define SRF_RST_SP           4'h0

// Program memory top address per variant size code.
`define SRF_PM_TOP_8K        16'h1FFF
`define SRF_PM_TOP_12K       16'h2FFF
`define SRF_PM_TOP_16K       16'h3FFF

// Table read latency in clocks (memory read register plus capture).
`define SRF_TBL_LAT          2'h2

`endif

/* File: design/srf_pkg.sv */
package srf_pkg;
  // Instruction codes presented by the decoder on one-cycle strobes.
  typedef enum logic [2:0] {
    SRF_OP_NONE,
    SRF_OP_TABLE_READ,
    SRF_OP_PUSH,
    SRF_OP_POP,
    SRF_OP_BRANCH,
    SRF_OP_CALL,
    SRF_OP_INC
  } srf_op_t;

  // Sequencer states of the register file.
  typedef enum logic [1:0] {
    SRF_IDLE,
    SRF_TBL_WAIT,
    SRF_POP_WAIT
  } srf_state_t;
endpackage : srf_pkg

/* File: design/srf_addr_stack.sv */
`timescale 1ns/1ps
`include "srf_consts.svh"
// Address stack: small register memory with a registered read port.
module srf_addr_stack
  import srf_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int DW    = 16
) (
  // Clock.
  input  wire logic          clk,
  // Write port.
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port, data one clock after the request.
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  // Contents are not reset; software never reads an entry it has not pushed.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read keeps the path from the stack to the pointer short.
  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : srf_addr_stack

/* File: design/srf_prog_rom.sv */
`timescale 1ns/1ps
// Program memory constant port: 16-bit words, registered read data.
module srf_prog_rom #(
  parameter int AW = 14,
  parameter int DW = 16
) (
  // Clock.
  input  wire logic          clk,
  // Loader write port, used by the system to fill the program store.
  input  wire logic          ld_en,
  input  wire logic [AW-1:0] ld_addr,
  input  wire logic [DW-1:0] ld_data,
  // Read port.
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];

  // Loader writes; no reset so the store maps onto a block memory.
  always_ff @(posedge clk) begin
    if (ld_en) begin
      mem[ld_addr] <= ld_data;
    end
  end

  // Read data come out of a register.
  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : srf_prog_rom

/* File: design/srf_system_register_set.sv */
`timescale 1ns/1ps
`include "srf_consts.svh"
module srf_system_register_set
  import srf_pkg::*;
#(
  parameter logic [1:0] PM_SIZE     = 2'h2,
  parameter int         STACK_DEPTH = 16,
  parameter int         SP_W        = 4,
  parameter int         PM_AW       = 14
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              resetn,
  // Synchronous reset causes and clock stop state.
  input  wire logic              watchdog_stack_fault_reset,
  input  wire logic              ce_reset,
  input  wire logic              clock_stop,
  // Data memory access from the datapath.
  input  wire logic              dm_wr,
  input  wire logic              dm_rd,
  input  wire logic [3:0]        dm_bank,
  input  wire logic [6:0]        dm_addr,
  input  wire logic [3:0]        dm_wdata,
  output logic      [3:0]        dm_rdata,
  output logic                   dm_hit,
  // Instruction strobe from the decoder.
  input  wire srf_op_t           op,
  input  wire logic [15:0]       return_addr,
  // Program memory loader.
  input  wire logic              pm_ld_en,
  input  wire logic [PM_AW-1:0]  pm_ld_addr,
  input  wire logic [15:0]       pm_ld_data,
  // Results to the core.
  output logic      [15:0]       data_buffer_reg,
  output logic                   dbf_valid,
  output logic      [15:0]       pc_load_value,
  output logic                   pc_load,
  output logic      [SP_W-1:0]   stack_ptr,
  output logic      [15:0]       prog_addr_pointer,
  output logic                   busy,
  output logic                   addr_range_err
);
  // Nibble select decode for the write path; the read path decodes dm_addr itself.
  function automatic logic [3:0] nib_sel(input logic [6:0] a);
    logic [3:0] s;
    s = 4'h0;
    case (a)
      `SRF_OFF_PA_HIGH:      s = 4'h8;
      `SRF_OFF_PA_UPPER_MID: s = 4'h4;
      `SRF_OFF_PA_LOWER_MID: s = 4'h2;
      `SRF_OFF_PA_LOW:       s = 4'h1;
      default:               s = 4'h0;
    endcase
    return s;
  endfunction : nib_sel

  // Highest program address for the variant.
  function automatic logic [15:0] pm_top(input logic [1:0] sz);
    logic [15:0] t;
    case (sz)
      2'h0:    t = `SRF_PM_TOP_8K;
      2'h1:    t = `SRF_PM_TOP_12K;
      default: t = `SRF_PM_TOP_16K;
    endcase
    return t;
  endfunction : pm_top

  srf_state_t        state_ff;
  logic [15:0]       ptr_ff;
  logic [15:0]       nxt_ptr;
  logic [SP_W-1:0]   sp_ff;
  logic [SP_W-1:0]   sp_dec;
  logic [3:0]        other_nib [8];
  logic              busy_ff;
  logic [3:0]        sel;
  logic              sys_hit;
  logic              soft_rst;
  logic              run;
  logic              stk_wr;
  logic              stk_rd;
  logic [15:0]       stk_wdata;
  logic [15:0]       stk_rdata;
  logic [15:0]       rom_rdata;
  logic              rom_rd;
  logic [15:0]       dbf_ff;
  logic              dbf_vld_ff;
  logic [15:0]       pc_ff;
  logic              pc_ld_ff;
  logic [3:0]        rdata_ff;
  logic              hit_ff;
  logic              err_ff;
  logic              tbl_cap;

  // The system set answers at row 7 columns 4..F in any bank.
  assign sys_hit  = (dm_addr >= `SRF_OFF_FIRST);
  assign sel      = nib_sel(dm_addr);
  assign soft_rst = watchdog_stack_fault_reset | ce_reset;
  // Clock stop blocks new instructions and nibble writes; soft resets and a pending pop still change the pointer.
  assign run      = ~clock_stop;
  assign sp_dec   = sp_ff - SP_W'(1);

  // Stack write on push, and on indirect call for the return address.
  assign stk_wr    = run && (op == SRF_OP_PUSH || op == SRF_OP_CALL) && state_ff == SRF_IDLE;
  assign stk_wdata = (op == SRF_OP_CALL) ? return_addr : ptr_ff;
  assign stk_rd    = run && op == SRF_OP_POP && state_ff == SRF_IDLE;
  assign rom_rd    = run && op == SRF_OP_TABLE_READ && state_ff == SRF_IDLE;
  assign tbl_cap   = state_ff == SRF_TBL_WAIT;

  srf_addr_stack #(
    .DEPTH (STACK_DEPTH),
    .AW    (SP_W),
    .DW    (16)
  ) u_stack (
    .clk     (clk),
    .wr_en   (stk_wr),
    .wr_addr (sp_dec),
    .wr_data (stk_wdata),
    .rd_en   (stk_rd),
    .rd_addr (sp_ff),
    .rd_data (stk_rdata)
  );

  srf_prog_rom #(
    .AW (PM_AW),
    .DW (16)
  ) u_rom (
    .clk     (clk),
    .ld_en   (pm_ld_en),
    .ld_addr (pm_ld_addr),
    .ld_data (pm_ld_data),
    .rd_en   (rom_rd),
    .rd_addr (ptr_ff[PM_AW-1:0]),
    .rd_data (rom_rdata)
  );

  // Next pointer value: pop result, increment, or nibble write.
  always_comb begin
    nxt_ptr = ptr_ff;
    if (state_ff == SRF_POP_WAIT) begin
      nxt_ptr = stk_rdata;
    end else if (run && op == SRF_OP_INC && state_ff == SRF_IDLE) begin
      nxt_ptr = ptr_ff + 16'h0001;
    end else if (run && dm_wr && sys_hit) begin
      // High nibble sits at the lowest address.
      for (int i = 0; i < 4; i++) begin
        if (sel[i]) begin
          nxt_ptr[i*4 +: 4] = dm_wdata;
        end
      end
    end
  end

  // Pointer register; soft resets act on the clock.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ptr_ff <= `SRF_RST_POINTER;
    end else if (soft_rst) begin
      ptr_ff <= `SRF_RST_POINTER;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // Stack pointer: decrement on push or call, increment after pop.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sp_ff <= `SRF_RST_SP;
    end else if (soft_rst) begin
      sp_ff <= `SRF_RST_SP;
    end else if (stk_wr) begin
      sp_ff <= sp_dec;
    end else if (stk_rd) begin
      sp_ff <= sp_ff + SP_W'(1);
    end
  end

  // Window, bank, index, group and status nibbles are plain storage here.
  // Their own behaviour lives in other blocks; only the shared map is kept.
  for (genvar g = 0; g < 8; g++) begin : g_other
    logic [3:0] nib_ff;
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        nib_ff <= `SRF_RST_NIBBLE;
      end else if (run && dm_wr && dm_addr == (`SRF_OFF_WINDOW + 7'(g))) begin
        nib_ff <= dm_wdata;
      end
    end
    assign other_nib[g] = nib_ff;
  end

  // Busy is registered so the decoder sees a level straight from a flip-flop.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
    end else if (soft_rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= rom_rd || stk_rd;
    end
  end

  // Sequencer for the two multi-cycle operations.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= SRF_IDLE;
    end else if (soft_rst) begin
      state_ff <= SRF_IDLE;
    end else begin
      case (state_ff)
        SRF_IDLE: begin
          if (rom_rd) begin
            state_ff <= SRF_TBL_WAIT;
          end else if (stk_rd) begin
            state_ff <= SRF_POP_WAIT;
          end
        end
        SRF_TBL_WAIT: state_ff <= SRF_IDLE;
        SRF_POP_WAIT: state_ff <= SRF_IDLE;
        default:      state_ff <= SRF_IDLE;
      endcase
    end
  end

  // Data buffer capture of the table word.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dbf_ff     <= 16'h0000;
      dbf_vld_ff <= 1'b0;
    end else begin
      dbf_vld_ff <= tbl_cap;
      if (tbl_cap) begin
        dbf_ff <= rom_rdata;
      end
    end
  end

  // Program counter load for indirect branch and call.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_ff    <= 16'h0000;
      pc_ld_ff <= 1'b0;
    end else begin
      pc_ld_ff <= run && state_ff == SRF_IDLE && (op == SRF_OP_BRANCH || op == SRF_OP_CALL);
      if (run && state_ff == SRF_IDLE && (op == SRF_OP_BRANCH || op == SRF_OP_CALL)) begin
        pc_ff <= ptr_ff;
      end
    end
  end

  // Registered read of the system nibbles, the same for every bank.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 4'h0;
      hit_ff   <= 1'b0;
    end else begin
      hit_ff <= dm_rd && sys_hit;
      if (dm_rd && sys_hit) begin
        case (dm_addr)
          `SRF_OFF_PA_HIGH:      rdata_ff <= ptr_ff[15:12];
          `SRF_OFF_PA_UPPER_MID: rdata_ff <= ptr_ff[11:8];
          `SRF_OFF_PA_LOWER_MID: rdata_ff <= ptr_ff[7:4];
          `SRF_OFF_PA_LOW:       rdata_ff <= ptr_ff[3:0];
          default:               rdata_ff <= other_nib[dm_addr[2:0]];
        endcase
      end
    end
  end

  // Flags a pointer beyond the variant's program memory; software must avoid it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= (ptr_ff > pm_top(PM_SIZE));
    end
  end

  assign data_buffer_reg   = dbf_ff;
  assign dbf_valid         = dbf_vld_ff;
  assign pc_load_value     = pc_ff;
  assign pc_load           = pc_ld_ff;
  assign stack_ptr         = sp_ff;
  assign prog_addr_pointer = ptr_ff;
  assign busy              = busy_ff;
  assign dm_rdata          = rdata_ff;
  assign dm_hit            = hit_ff;
  assign addr_range_err    = err_ff;
endmodule : srf_system_register_set

/* File: bench/srf_checker.sv */
`timescale 1ns/1ps
module srf_checker
  import srf_pkg::*;
#(
  parameter int SP_W = 4
) (
  // Clock, reset and causes.
  input wire logic            clk,
  input wire logic            resetn,
  input wire logic            watchdog_stack_fault_reset,
  input wire logic            ce_reset,
  input wire logic            clock_stop,
  // Core requests.
  input wire logic            dm_wr,
  input wire logic            dm_rd,
  input wire logic [6:0]      dm_addr,
  input wire logic [3:0]      dm_wdata,
  input wire srf_op_t         op,
  // Results.
  input wire logic            dm_hit,
  input wire logic            dbf_valid,
  input wire logic            pc_load,
  input wire logic [15:0]     pc_load_value,
  input wire logic [SP_W-1:0] stack_ptr,
  input wire logic [15:0]     prog_addr_pointer,
  input wire logic            busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // An instruction is taken only on an edge that nothing else claims.
  wire logic go;
  assign go = !busy && !clock_stop && !watchdog_stack_fault_reset && !ce_reset;
  sequence tbl_req_s;
    go && op == SRF_OP_TABLE_READ;
  endsequence
  sequence tbl_done_s;
    ##[2:3] dbf_valid;
  endsequence
  soft_clear_a: assert property ((ce_reset || watchdog_stack_fault_reset) |=> prog_addr_pointer == 16'h0000 && stack_ptr == '0)
    else $error("pointer not cleared by soft reset");
  stop_hold_a: assert property (clock_stop && !busy && !ce_reset && !watchdog_stack_fault_reset |=> $stable(prog_addr_pointer))
    else $error("pointer moved during clock stop");
  tbl_answer_a: assert property (tbl_req_s |-> tbl_done_s)
    else $error("table read gave no data");
  push_step_a: assert property (go && op == SRF_OP_PUSH |=> stack_ptr == $past(stack_ptr) - 1'b1)
    else $error("push did not lower stack pointer");
  branch_pc_a: assert property (go && op == SRF_OP_BRANCH |=> pc_load && pc_load_value == $past(prog_addr_pointer))
    else $error("branch target wrong");
  call_push_a: assert property (go && op == SRF_OP_CALL |=> pc_load && stack_ptr == $past(stack_ptr) - 1'b1)
    else $error("call did not load pc and push");
  inc_carry_a: assert property (go && op == SRF_OP_INC && !dm_wr |=> prog_addr_pointer == $past(prog_addr_pointer) + 16'h1)
    else $error("increment wrong");
  nib_order_a: assert property (go && dm_wr && op == SRF_OP_NONE && dm_addr == 7'h74 |=> prog_addr_pointer[15:12] == $past(dm_wdata))
    else $error("high nibble not at 74H");
  shared_hit_a: assert property (dm_rd |=> dm_hit == ($past(dm_addr) >= 7'h74))
    else $error("system nibble decode wrong");
endmodule : srf_checker

bind srf_system_register_set srf_checker #(.SP_W(SP_W)) u_chk (.clk(clk), .resetn(resetn), .watchdog_stack_fault_reset(watchdog_stack_fault_reset),
  .ce_reset(ce_reset), .clock_stop(clock_stop), .dm_wr(dm_wr), .dm_rd(dm_rd), .dm_addr(dm_addr),
  .dm_wdata(dm_wdata), .op(op), .dm_hit(dm_hit), .dbf_valid(dbf_valid), .pc_load(pc_load),
  .pc_load_value(pc_load_value), .stack_ptr(stack_ptr), .prog_addr_pointer(prog_addr_pointer), .busy(busy));

/* File: bench/srf_core_model.sv */
`timescale 1ns/1ps
module srf_core_model
  import srf_pkg::*;
(
  // Clock and status.
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic [3:0]  dm_rdata,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_load_value,
  input  wire logic        dbf_valid,
  input  wire logic [15:0] data_buffer_reg,
  // Requests.
  output logic             dm_wr,
  output logic             dm_rd,
  output logic      [3:0]  dm_bank,
  output logic      [6:0]  dm_addr,
  output logic      [3:0]  dm_wdata,
  output srf_op_t          op,
  output logic      [15:0] return_addr
);
  logic [15:0] pc_seen;
  logic [15:0] dbf_seen;
  // Everything idles low at time zero.
  initial begin
    {dm_wr, dm_rd, dm_bank, dm_addr, dm_wdata, return_addr} = '0;
    op = SRF_OP_NONE;
  end
  // Result pulses last one cycle, so they are caught on the clock.
  always @(posedge clk) begin
    if (pc_load) pc_seen <= pc_load_value;
    if (dbf_valid) dbf_seen <= data_buffer_reg;
  end
  // Strobes one instruction once the sequencer is free.
  task automatic issue(input srf_op_t o, input logic [15:0] ra);
    @(negedge clk);
    while (busy) @(negedge clk);
    @(posedge clk);
    op <= o;
    return_addr <= ra;
    @(posedge clk);
    op <= SRF_OP_NONE;
    return_addr <= ~ra;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : issue
  // One nibble access; released lines show the inverse so stale values are not trusted.
  task automatic acc(input logic w, input logic [6:0] a, input logic [3:0] d, output logic [3:0] r);
    @(posedge clk);
    dm_wr <= w;
    dm_rd <= !w;
    dm_bank <= 4'($urandom);
    dm_addr <= a;
    dm_wdata <= d;
    @(posedge clk);
    {dm_wr, dm_rd} <= 2'h0;
    dm_addr <= ~a;
    dm_wdata <= ~d;
    @(posedge clk);
    @(negedge clk);
    r = dm_rdata;
  endtask : acc
  // Loads the pointer nibble by nibble; normal code keeps it inside program memory.
  task automatic ld(input logic [15:0] v, input logic raw);
    logic [3:0] r;
    v = raw ? v : v & 16'h3FFF;
    for (int i = 0; i < 4; i++) acc(1'b1, 7'h74 + 7'(i), v[15-4*i -: 4], r);
  endtask : ld
endmodule : srf_core_model

/* File: bench/test_system_register_file_addr_reg.sv */
`timescale 1ns/1ps
module test_system_register_file_addr_reg;
  import srf_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, watchdog_stack_fault_reset = 1'b0, ce_reset = 1'b0, clock_stop = 1'b0, pm_ld_en = 1'b0;
  logic [13:0] pm_ld_addr = '0;
  logic [15:0] pm_ld_data = '0, v;
  logic [3:0]  r;
  wire logic dm_wr, dm_rd, dm_hit, dbf_valid, pc_load, busy, addr_range_err;
  wire logic [3:0]  dm_bank, dm_wdata, dm_rdata, stack_ptr;
  wire logic [6:0]  dm_addr;
  wire logic [15:0] return_addr, data_buffer_reg, pc_load_value, prog_addr_pointer;
  wire srf_op_t     op;
  int err_count = 0, checks_done = 0, ref_ptr = 0, ref_sp = 0, ref_stk[16];
  int ref_rom[int];
  always #50 clk = ~clk;
  srf_system_register_set DUT (.clk(clk), .resetn(resetn), .watchdog_stack_fault_reset(watchdog_stack_fault_reset), .ce_reset(ce_reset),
    .clock_stop(clock_stop), .dm_wr(dm_wr), .dm_rd(dm_rd), .dm_bank(dm_bank), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .dm_hit(dm_hit), .op(op), .return_addr(return_addr),
    .pm_ld_en(pm_ld_en), .pm_ld_addr(pm_ld_addr), .pm_ld_data(pm_ld_data), .data_buffer_reg(data_buffer_reg),
    .dbf_valid(dbf_valid), .pc_load_value(pc_load_value), .pc_load(pc_load), .stack_ptr(stack_ptr),
    .prog_addr_pointer(prog_addr_pointer), .busy(busy), .addr_range_err(addr_range_err));
  srf_core_model DEC (.clk(clk), .busy(busy), .dm_rdata(dm_rdata), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .dbf_valid(dbf_valid), .data_buffer_reg(data_buffer_reg), .dm_wr(dm_wr),
    .dm_rd(dm_rd), .dm_bank(dm_bank), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .op(op), .return_addr(return_addr));
  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic setp(input logic [15:0] x, input logic raw);
    DEC.ld(x, raw);
    ref_ptr = x;
  endtask : setp
  // Runs one instruction on the design and on the reference, then compares.
  task automatic run(input srf_op_t o, input logic [15:0] ra);
    DEC.issue(o, ra);
    if (o == SRF_OP_BRANCH || o == SRF_OP_CALL) chk("pc", DEC.pc_seen, ref_ptr[15:0]);
    if (o == SRF_OP_TABLE_READ) chk("dbf", DEC.dbf_seen, ref_rom[ref_ptr][15:0]);
    if (o == SRF_OP_PUSH || o == SRF_OP_CALL) begin
      ref_sp = (ref_sp + 15) % 16;
      ref_stk[ref_sp] = (o == SRF_OP_CALL) ? ra : ref_ptr;
    end
    if (o == SRF_OP_POP) begin
      ref_ptr = ref_stk[ref_sp];
      ref_sp = (ref_sp + 1) % 16;
    end
    if (o == SRF_OP_INC) ref_ptr = (ref_ptr + 1) % 65536;
    chk("pointer", prog_addr_pointer, ref_ptr[15:0]);
    chk("sp", {12'h000, stack_ptr}, ref_sp[15:0]);
  endtask : run
  // Watchdog at 20000 cycles, well beyond the few hundred cycles the tests need.
  initial begin
    #2000000;
    err_count++;
    conclude();
  end
  // Main sequence.
  initial begin
    void'($urandom(40));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      DEC.acc(1'b0, 7'h74 + 7'(i), 4'h0, r);
      chk("nibble", {12'h000, r}, 16'h0000);
    end
    $display("Test reset done");
    repeat (3) begin
      v = 16'($urandom) & 16'h3FFF;
      setp(v, 1'b0);
      chk("pointer", prog_addr_pointer, v);
      for (int i = 0; i < 4; i++) begin
        DEC.acc(1'b0, 7'h74 + 7'(i), 4'h0, r);
        chk("nibble", {12'h000, r}, {12'h000, v[15-4*i -: 4]});
      end
    end
    $display("Test nibble map done");
    setp(16'h0FFF, 1'b0);
    chk("range", {15'h0000, addr_range_err}, 16'h0000);
    run(SRF_OP_INC, 16'h0000);
    setp(16'hFFFF, 1'b1);
    chk("range", {15'h0000, addr_range_err}, 16'h0001);
    run(SRF_OP_INC, 16'h0000);
    $display("Test increment done");
    foreach (ref_stk[i]) if (i < 4) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h3FFF : 16'($urandom) & 16'h3FFF;
      @(posedge clk);
      {pm_ld_en, pm_ld_addr, pm_ld_data} <= {1'b1, v[13:0], 16'($urandom)};
      @(posedge clk);
      pm_ld_en <= 1'b0;
      ref_rom[v] = pm_ld_data;
      setp(v, 1'b0);
      run(SRF_OP_TABLE_READ, 16'h0000);
    end
    $display("Test table read done");
    repeat (3) begin
      setp(16'($urandom) & 16'h3FFF, 1'b0);
      run(SRF_OP_PUSH, 16'h0000);
    end
    repeat (3) run(SRF_OP_POP, 16'h0000);
    $display("Test stack done");
    setp(16'($urandom) & 16'h3FFF, 1'b0);
    run(SRF_OP_BRANCH, 16'h0000);
    run(SRF_OP_CALL, 16'($urandom) & 16'h3FFF);
    run(SRF_OP_POP, 16'h0000);
    $display("Test branch call done");
    clock_stop <= 1'b1;
    DEC.issue(SRF_OP_INC, 16'h0000);
    DEC.ld(16'h1234, 1'b0);
    clock_stop <= 1'b0;
    chk("pointer", prog_addr_pointer, ref_ptr[15:0]);
    $display("Test clock stop done");
    for (int k = 0; k < 2; k++) begin
      setp(16'h2A5C, 1'b0);
      run(SRF_OP_PUSH, 16'h0000);
      @(posedge clk);
      {ce_reset, watchdog_stack_fault_reset} <= k ? 2'h1 : 2'h2;
      @(posedge clk);
      {ce_reset, watchdog_stack_fault_reset} <= 2'h0;
      @(negedge clk);
      {ref_ptr, ref_sp} = '0;
      chk("pointer", prog_addr_pointer, 16'h0000);
      chk("sp", {12'h000, stack_ptr}, 16'h0000);
    end
    setp(16'h1357, 1'b0);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    ref_ptr = 0;
    chk("pointer", prog_addr_pointer, 16'h0000);
    $display("Test soft reset done");
    conclude();
  end
endmodule : test_system_register_file_addr_reg
